// file: shared/uart_iid_regs.svh
// What this block does
// - pending interrupts rank: line status, received data, holding empty, modem status
// - identification value stays steady for the whole host read access
// - bit 0 reads 0 while an enabled interrupt pends, else 1
// - bits 2:1 give 11 line, 10 data/timeout, 01 holding, 00 modem
// - bit 3 is 0 outside fifo mode; timeout in fifo mode reads 1100
// - timeout when queue non-empty and untouched for four character times
// - identification bits 5 and 4 always read zero
// - identification bits 7:6 read 11 in fifo mode, else 00
// - identification register reads at offset 2 whatever divisor select says
// - line-format bits 1:0 pick five, six, seven or eight data bits
// - word length counts data bits only, framing bits added elsewhere
// - enable bits 0..3 gate data, holding, line status, modem status
// - line status source is overrun, parity, framing or break
// - modem status source is any change of a modem status indicator
// - interrupt pin driven only while the output-2 gate bit is 1
`ifndef UART_IID_REGS_SVH
`define UART_IID_REGS_SVH

// register offsets
`define OFS_BUFFER        3'h0
`define OFS_ENABLE        3'h1
`define OFS_IID           3'h2
`define OFS_FORMAT        3'h3
`define OFS_MODEM_CTRL    3'h4
`define OFS_LINE_STATUS   3'h5
`define OFS_MODEM_STATUS  3'h6

// reset values and read masks
`define RST_BYTE          8'h00
`define ENABLE_MASK       8'h0f
`define MODEM_CTRL_MASK   8'h1f

// enable bit positions
`define ENA_RXDATA        0
`define ENA_THRE          1
`define ENA_LINE          2
`define ENA_MODEM         3

// fifo setup fields
`define FSET_ENABLE       0
`define FSET_RXCLR        1
`define FSET_TXCLR        2
`define FSET_TRIG_HI      7
`define FSET_TRIG_LO      6

// line format and modem control fields
`define FMT_DIVSEL        7
`define FMT_WLEN_HI       1
`define FMT_WLEN_LO       0
`define MCTL_GATE         3

// identification codes, low nibble, then the bit 7:6 and bit 5:4 fields
`define IID_NONE          4'h1
`define IID_LINE          4'h6
`define IID_RXDATA        4'h4
`define IID_TIMEOUT       4'hc
`define IID_THRE          4'h2
`define IID_MODEM         4'h0
`define IID_FIFO_FLAGS    2'h3
`define IID_NO_FLAGS      2'h0
`define IID_ZERO_BITS     2'h0

// receive trigger levels in bytes
`define TRIG_1            5'h01
`define TRIG_4            5'h04
`define TRIG_8            5'h08
`define TRIG_14           5'h0e

// word length and timeout
`define WORD_LEN_MIN      4'h5
`define TIMEOUT_CHARS     3'h4

`endif

// file: shared/uart_iid_pkg.sv
`default_nettype none
package uart_iid_pkg;

   // highest pending source, in order of rank
   typedef enum logic [2:0] {
      SRC_NONE,
      SRC_LINE,
      SRC_RXDATA,
      SRC_TIMEOUT,
      SRC_THRE,
      SRC_MODEM
   } int_source_t;

endpackage : uart_iid_pkg
`default_nettype wire

// file: logic/char_timeout.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_iid_regs.svh"

module char_timeout #(
   parameter logic [2:0] CHARS = `TIMEOUT_CHARS
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_b,
   // queue activity
   input  wire logic fifo_mode,
   input  wire logic queue_push,
   input  wire logic queue_pop,
   input  wire logic queue_nonempty,
   input  wire logic char_tick,
   // result
   output var  logic timeout
);

   logic [2:0] count_reg;
   logic [2:0] count_next;
   logic       flag_reg;
   logic       flag_next;

   // any movement or an empty queue restarts the wait
   always_comb
   begin
      count_next = count_reg;
      flag_next  = flag_reg;
      if (!fifo_mode || queue_push || queue_pop || !queue_nonempty)
      begin
         count_next = 3'h0;
         flag_next  = 1'b0;
      end
      else if (char_tick && count_reg != CHARS)
      begin
         count_next = count_reg + 3'h1;
         flag_next  = (count_reg + 3'h1) == CHARS;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         count_reg <= 3'h0;
         flag_reg  <= 1'b0;
      end
      else
      begin
         count_reg <= count_next;
         flag_reg  <= flag_next;
      end
   end

   assign timeout = flag_reg;

endmodule : char_timeout
`default_nettype wire

// file: logic/uart_interrupt_identification.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_iid_regs.svh"

module uart_interrupt_identification #(
   parameter int LEVEL_W = 5
) (
   // clock and reset
   input  wire logic               REF_CLK,
   input  wire logic               RST_B,
   // host register port, asynchronous pins
   input  wire logic [2:0]         HOST_ADDR,
   input  wire logic               HOST_RD_B,
   input  wire logic               HOST_WR_B,
   input  wire logic [7:0]         HOST_DATA_IN,
   output logic      [7:0]         HOST_DATA_OUT,
   output logic                    HOST_DATA_OE_B,
   // events from the rest of the port
   input  wire logic [3:0]         LINE_ERROR,
   input  wire logic [3:0]         MODEM_DELTA,
   input  wire logic               THR_EMPTY_EVENT,
   input  wire logic               RX_PUSH,
   input  wire logic [LEVEL_W-1:0] RX_LEVEL,
   input  wire logic               CHAR_TIME_TICK,
   // interrupt pin
   output logic                    IRQ,
   output logic                    IRQ_OE_B,
   // settings and strobes to the rest of the port
   output logic      [7:0]         LINE_FORMAT,
   output logic      [3:0]         DATA_BITS,
   output logic                    FIFO_MODE,
   output logic      [7:0]         MODEM_CTRL,
   output logic                    RX_QUEUE_CLEAR,
   output logic                    TX_QUEUE_CLEAR,
   output logic                    BUFFER_READ,
   output logic                    HOLDING_WRITE,
   output logic                    LINE_STATUS_READ,
   output logic                    MODEM_STATUS_READ
);

   // pin synchroniser: rd, wr, addr, data
   localparam int PIN_W = 13;
   logic [PIN_W-1:0] pin_meta_reg;
   logic [PIN_W-1:0] pin_sync_reg;
   logic             rd_prev_reg;
   logic             wr_prev_reg;

   // register file state
   logic [7:0]         enable_reg;
   logic [7:0]         enable_next;
   logic [7:0]         format_reg;
   logic [7:0]         format_next;
   logic [7:0]         mctl_reg;
   logic [7:0]         mctl_next;
   logic               fifo_mode_reg;
   logic               fifo_mode_next;
   logic [1:0]         trig_sel_reg;
   logic [1:0]         trig_sel_next;
   logic               rxclr_reg;
   logic               rxclr_next;
   logic               txclr_reg;
   logic               txclr_next;

   // pending sources and host answer
   logic               line_pend_reg;
   logic               line_pend_next;
   logic               modem_pend_reg;
   logic               modem_pend_next;
   logic               thre_pend_reg;
   logic               thre_pend_next;
   logic               thre_seen_reg;
   logic               thre_seen_next;
   logic [7:0]         dout_reg;
   logic [7:0]         dout_next;
   logic               oe_b_reg;
   logic               oe_b_next;
   logic [3:0]         strobe_reg;
   logic [3:0]         strobe_next;
   logic               irq_reg;
   logic               irq_next;

   // decoded host access
   logic               rd_b;
   logic               wr_b;
   logic [2:0]         addr;
   logic [7:0]         din;
   logic               rd_start;
   logic               rd_end;
   logic               wr_done;
   logic               divsel;

   // interrupt evaluation
   logic                    timeout;
   logic [LEVEL_W-1:0]      trig_level;
   logic                    rx_at_trig;
   uart_iid_pkg::int_source_t source;
   logic [3:0]              iid_code;
   logic [7:0]              iid_byte;

   // two flops per pin before anything looks at them
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         pin_meta_reg <= {2'h3, 11'h000};
         pin_sync_reg <= {2'h3, 11'h000};
         rd_prev_reg  <= 1'b1;
         wr_prev_reg  <= 1'b1;
      end
      else
      begin
         pin_meta_reg <= {HOST_RD_B, HOST_WR_B, HOST_ADDR, HOST_DATA_IN};
         pin_sync_reg <= pin_meta_reg;
         rd_prev_reg  <= pin_sync_reg[12];
         wr_prev_reg  <= pin_sync_reg[11];
      end
   end

   // address and data are stable for the whole strobe, so a plain sync is safe
   assign rd_b     = pin_sync_reg[12];
   assign wr_b     = pin_sync_reg[11];
   assign addr     = pin_sync_reg[10:8];
   assign din      = pin_sync_reg[7:0];
   assign rd_start = !rd_b && rd_prev_reg;
   assign rd_end   = rd_b && !rd_prev_reg;
   assign wr_done  = wr_b && !wr_prev_reg;   // write lands at strobe release
   assign divsel   = format_reg[`FMT_DIVSEL];

   // host writes into the register file
   always_comb
   begin
      enable_next    = enable_reg;
      format_next    = format_reg;
      mctl_next      = mctl_reg;
      fifo_mode_next = fifo_mode_reg;
      trig_sel_next  = trig_sel_reg;
      rxclr_next     = 1'b0;
      txclr_next     = 1'b0;
      if (wr_done)
      begin
         case (addr)
            `OFS_ENABLE:
               if (!divsel)
                  enable_next = din & `ENABLE_MASK;
            `OFS_IID:
            begin
               fifo_mode_next = din[`FSET_ENABLE];
               // other fields only take while the enable bit is written as 1
               if (din[`FSET_ENABLE])
               begin
                  trig_sel_next = din[`FSET_TRIG_HI:`FSET_TRIG_LO];
                  rxclr_next    = din[`FSET_RXCLR];
                  txclr_next    = din[`FSET_TXCLR];
               end
               // leaving fifo mode empties both queues
               if (fifo_mode_reg && !din[`FSET_ENABLE])
               begin
                  rxclr_next = 1'b1;
                  txclr_next = 1'b1;
               end
            end
            `OFS_FORMAT:
               format_next = din;
            `OFS_MODEM_CTRL:
               mctl_next = din & `MODEM_CTRL_MASK;
            default:
               enable_next = enable_reg;
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         enable_reg    <= `RST_BYTE;
         format_reg    <= `RST_BYTE;
         mctl_reg      <= `RST_BYTE;
         fifo_mode_reg <= 1'b0;
         trig_sel_reg  <= 2'h0;
         rxclr_reg     <= 1'b0;
         txclr_reg     <= 1'b0;
      end
      else
      begin
         enable_reg    <= enable_next;
         format_reg    <= format_next;
         mctl_reg      <= mctl_next;
         fifo_mode_reg <= fifo_mode_next;
         trig_sel_reg  <= trig_sel_next;
         rxclr_reg     <= rxclr_next;
         txclr_reg     <= txclr_next;
      end
   end

   // character timeout watch on the receive queue
   char_timeout #(
      .CHARS          (`TIMEOUT_CHARS)
   ) u_timeout (
      .ref_clk        (REF_CLK),
      .rst_b          (RST_B),
      .fifo_mode      (fifo_mode_reg),
      .queue_push     (RX_PUSH),
      .queue_pop      (strobe_reg[0]),
      .queue_nonempty (RX_LEVEL != '0),
      .char_tick      (CHAR_TIME_TICK),
      .timeout        (timeout)
   );

   // trigger threshold; outside fifo mode one byte is enough
   always_comb
   begin
      unique case (trig_sel_reg)
         2'h0: trig_level = LEVEL_W'(`TRIG_1);
         2'h1: trig_level = LEVEL_W'(`TRIG_4);
         2'h2: trig_level = LEVEL_W'(`TRIG_8);
         2'h3: trig_level = LEVEL_W'(`TRIG_14);
      endcase
      rx_at_trig = fifo_mode_reg ? (RX_LEVEL >= trig_level) : (RX_LEVEL != '0);
   end

   // pick the highest enabled source; data outranks timeout at equal level
   always_comb
   begin
      if (line_pend_reg && enable_reg[`ENA_LINE])
         source = uart_iid_pkg::SRC_LINE;
      else if (rx_at_trig && enable_reg[`ENA_RXDATA])
         source = uart_iid_pkg::SRC_RXDATA;
      else if (timeout && enable_reg[`ENA_RXDATA])
         source = uart_iid_pkg::SRC_TIMEOUT;
      else if (thre_pend_reg && enable_reg[`ENA_THRE])
         source = uart_iid_pkg::SRC_THRE;
      else if (modem_pend_reg && enable_reg[`ENA_MODEM])
         source = uart_iid_pkg::SRC_MODEM;
      else
         source = uart_iid_pkg::SRC_NONE;
      unique case (source)
         uart_iid_pkg::SRC_NONE:    iid_code = `IID_NONE;
         uart_iid_pkg::SRC_LINE:    iid_code = `IID_LINE;
         uart_iid_pkg::SRC_RXDATA:  iid_code = `IID_RXDATA;
         uart_iid_pkg::SRC_TIMEOUT: iid_code = `IID_TIMEOUT;
         uart_iid_pkg::SRC_THRE:    iid_code = `IID_THRE;
         uart_iid_pkg::SRC_MODEM:   iid_code = `IID_MODEM;
         default:                   iid_code = `IID_NONE;
      endcase
      iid_byte = {fifo_mode_reg ? `IID_FIFO_FLAGS : `IID_NO_FLAGS,
                  `IID_ZERO_BITS, iid_code};
   end

   // sticky sources, host answer and access strobes
   always_comb
   begin
      line_pend_next  = line_pend_reg;
      modem_pend_next = modem_pend_reg;
      thre_pend_next  = thre_pend_reg;
      thre_seen_next  = thre_seen_reg;
      dout_next       = dout_reg;
      oe_b_next       = oe_b_reg;
      strobe_next     = 4'h0;
      // read start: sample once, the value then stands until release
      if (rd_start)
      begin
         oe_b_next      = 1'b0;
         thre_seen_next = 1'b0;
         case (addr)
            `OFS_ENABLE:
               dout_next = divsel ? `RST_BYTE : enable_reg;
            `OFS_IID:
            begin
               dout_next      = iid_byte;
               thre_seen_next = (source == uart_iid_pkg::SRC_THRE);
            end
            `OFS_FORMAT:
               dout_next = format_reg;
            `OFS_MODEM_CTRL:
               dout_next = mctl_reg;
            default:
               dout_next = `RST_BYTE;   // served by the data and status logic
         endcase
         strobe_next[0] = (addr == `OFS_BUFFER) && !divsel;
         strobe_next[2] = (addr == `OFS_LINE_STATUS);
         strobe_next[3] = (addr == `OFS_MODEM_STATUS);
      end
      if (rd_end)
         oe_b_next = 1'b1;
      strobe_next[1] = wr_done && (addr == `OFS_BUFFER) && !divsel;
      // clears first, so a same-cycle event still wins
      if (strobe_reg[2])
         line_pend_next = 1'b0;
      if (strobe_reg[3])
         modem_pend_next = 1'b0;
      if (strobe_reg[1] || (rd_end && thre_seen_reg))
         thre_pend_next = 1'b0;
      if (rd_end)
         thre_seen_next = 1'b0;
      if (LINE_ERROR != 4'h0)
         line_pend_next = 1'b1;
      if (MODEM_DELTA != 4'h0)
         modem_pend_next = 1'b1;
      if (THR_EMPTY_EVENT)
         thre_pend_next = 1'b1;
      irq_next = (source != uart_iid_pkg::SRC_NONE) && mctl_reg[`MCTL_GATE];
   end

   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         line_pend_reg  <= 1'b0;
         modem_pend_reg <= 1'b0;
         thre_pend_reg  <= 1'b0;
         thre_seen_reg  <= 1'b0;
         dout_reg       <= `RST_BYTE;
         oe_b_reg       <= 1'b1;
         strobe_reg     <= 4'h0;
         irq_reg        <= 1'b0;
      end
      else
      begin
         line_pend_reg  <= line_pend_next;
         modem_pend_reg <= modem_pend_next;
         thre_pend_reg  <= thre_pend_next;
         thre_seen_reg  <= thre_seen_next;
         dout_reg       <= dout_next;
         oe_b_reg       <= oe_b_next;
         strobe_reg     <= strobe_next;
         irq_reg        <= irq_next;
      end
   end

   // outputs; data length counts payload bits only, framing is added downstream
   assign HOST_DATA_OUT     = dout_reg;
   assign HOST_DATA_OE_B    = oe_b_reg;
   assign IRQ               = irq_reg;
   assign IRQ_OE_B          = !mctl_reg[`MCTL_GATE];
   assign LINE_FORMAT       = format_reg;
   assign DATA_BITS         = `WORD_LEN_MIN
                              + {2'h0, format_reg[`FMT_WLEN_HI:`FMT_WLEN_LO]};
   assign FIFO_MODE         = fifo_mode_reg;
   assign MODEM_CTRL        = mctl_reg;
   assign RX_QUEUE_CLEAR    = rxclr_reg;
   assign TX_QUEUE_CLEAR    = txclr_reg;
   assign BUFFER_READ       = strobe_reg[0];
   assign HOLDING_WRITE     = strobe_reg[1];
   assign LINE_STATUS_READ  = strobe_reg[2];
   assign MODEM_STATUS_READ = strobe_reg[3];

endmodule : uart_interrupt_identification
`default_nettype wire

// file: tb/uart_iid_checker.sv
`timescale 1ns/1ps
`default_nettype none

module uart_iid_checker (
   // clock and reset
   input  wire logic       REF_CLK,
   input  wire logic       RST_B,
   // host side
   input  wire logic [2:0] HOST_ADDR,
   input  wire logic       HOST_RD_B,
   input  wire logic [7:0] HOST_DATA_OUT,
   input  wire logic       HOST_DATA_OE_B,
   // interrupt pin and settings
   input  wire logic       IRQ,
   input  wire logic       IRQ_OE_B,
   input  wire logic [7:0] LINE_FORMAT,
   input  wire logic [3:0] DATA_BITS,
   input  wire logic       FIFO_MODE,
   input  wire logic [7:0] MODEM_CTRL
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);

   // identification bytes on the bus; address is held for the whole access
   wire logic iid_out = !HOST_DATA_OE_B && (HOST_ADDR == 3'h2);

   // pin strobe goes through two sync flops before the bus is driven
   oe_timing_a: assert property ($fell(HOST_RD_B) |-> ##[2:3] !HOST_DATA_OE_B)
      else $error("data bus not driven after read strobe");
   oe_release_a: assert property ($rose(HOST_RD_B) |-> ##[2:3] HOST_DATA_OE_B)
      else $error("data bus not released after read strobe");
   read_freeze_a: assert property (!HOST_DATA_OE_B && $past(!HOST_DATA_OE_B) |-> $stable(HOST_DATA_OUT))
      else $error("read data moved during access");
   zero_bits_a: assert property (iid_out |-> HOST_DATA_OUT[5:4] == 2'h0)
      else $error("identification bits 5:4 not zero");
   fifo_flags_a: assert property (iid_out |-> HOST_DATA_OUT[7:6] == {2{FIFO_MODE}})
      else $error("identification bits 7:6 disagree with fifo mode");
   idle_code_a: assert property (iid_out && HOST_DATA_OUT[0] |-> HOST_DATA_OUT[3:1] == 3'h0)
      else $error("no-pending code carries a source");
   bit3_plain_a: assert property (iid_out && !FIFO_MODE |-> !HOST_DATA_OUT[3])
      else $error("bit 3 set outside fifo mode");
   word_len_a: assert property ($stable(LINE_FORMAT) ##1 $stable(LINE_FORMAT)
         |-> DATA_BITS == {2'h0, LINE_FORMAT[1:0]} + 4'h5)
      else $error("data bit count disagrees with line format");
   pin_gate_a: assert property (IRQ_OE_B == !MODEM_CTRL[3])
      else $error("interrupt pin enable disagrees with gate bit");
   irq_gate_a: assert property (!MODEM_CTRL[3] && $past(!MODEM_CTRL[3]) |-> !IRQ)
      else $error("interrupt raised while gated off");

   // main scenarios seen
   iid_read_c: cover property (iid_out && !HOST_DATA_OUT[0]);
   irq_rise_c: cover property ($rose(IRQ));
   timeout_c: cover property (iid_out && HOST_DATA_OUT[3:0] == 4'hc);
endmodule : uart_iid_checker

bind uart_interrupt_identification uart_iid_checker uart_iid_checker_inst (
   .REF_CLK(REF_CLK), .RST_B(RST_B), .HOST_ADDR(HOST_ADDR), .HOST_RD_B(HOST_RD_B),
   .HOST_DATA_OUT(HOST_DATA_OUT), .HOST_DATA_OE_B(HOST_DATA_OE_B), .IRQ(IRQ),
   .IRQ_OE_B(IRQ_OE_B), .LINE_FORMAT(LINE_FORMAT), .DATA_BITS(DATA_BITS),
   .FIFO_MODE(FIFO_MODE), .MODEM_CTRL(MODEM_CTRL));

`default_nettype wire

// file: tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_model (
   // clock
   input  wire logic       clk,
   // register pins
   output var  logic [2:0] addr,
   output var  logic       rd_b,
   output var  logic       wr_b,
   output var  logic [7:0] wdata,
   input  wire logic [7:0] rdata
);
   // idle bus from time zero
   initial
   begin
      addr = 3'h0;
      rd_b = 1'b1;
      wr_b = 1'b1;
      wdata = 8'h00;
   end

   // write strobes held 4 cycles, read strobes 6, gaps of 5, well above the 3-cycle sync minimum
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_b <= 1'b0;
      repeat (4) @(posedge clk);
      wr_b <= 1'b1;
      repeat (5) @(posedge clk);
      wdata <= ~d; // released data never repeats the old value
   endtask : wr

   // data taken at the last edge of the strobe, where it stands frozen
   task rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_b <= 1'b0;
      repeat (6) @(posedge clk);
      d = rdata;
      rd_b <= 1'b1;
      repeat (5) @(posedge clk);
   endtask : rd
endmodule : host_model

`default_nettype wire

// file: tb/uart_interrupt_identification_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         bad_count++; \
         $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
      end \
   end

module uart_interrupt_identification_tb_top;
   logic       ref_clk = 1'b0;
   logic       rst_b = 1'b0;
   logic [2:0] addr;
   logic       rd_b, wr_b, thr_ev, rx_push, tick, irq, irq_oe_b;
   logic [7:0] wdata, rdata, d;
   logic [3:0] line_err = 4'h0, modem_dl = 4'h0, data_bits;
   logic [4:0] rx_level = 5'h00;
   int         bad_count = 0, samples_checked = 0, cycles = 0;
   wire logic  pop_s, hold_s, lsr_s, msr_s, rxclr_s, txclr_s;
   logic [3:0] n_pop = 4'h0, n_hold = 4'h0, n_lsr = 4'h0;
   logic [3:0] n_msr = 4'h0, n_rxclr = 4'h0, n_txclr = 4'h0;

   initial {thr_ev, rx_push, tick} = 3'h0;
   always #2 ref_clk = ~ref_clk;

   host_model host_model_inst (.clk(ref_clk), .addr(addr), .rd_b(rd_b), .wr_b(wr_b),
      .wdata(wdata), .rdata(rdata));

   uart_interrupt_identification uart_interrupt_identification_inst (
      .REF_CLK(ref_clk), .RST_B(rst_b), .HOST_ADDR(addr), .HOST_RD_B(rd_b),
      .HOST_WR_B(wr_b), .HOST_DATA_IN(wdata), .HOST_DATA_OUT(rdata), .HOST_DATA_OE_B(),
      .LINE_ERROR(line_err), .MODEM_DELTA(modem_dl), .THR_EMPTY_EVENT(thr_ev),
      .RX_PUSH(rx_push), .RX_LEVEL(rx_level), .CHAR_TIME_TICK(tick), .IRQ(irq),
      .IRQ_OE_B(irq_oe_b), .LINE_FORMAT(), .DATA_BITS(data_bits), .FIFO_MODE(),
      .MODEM_CTRL(), .RX_QUEUE_CLEAR(rxclr_s), .TX_QUEUE_CLEAR(txclr_s), .BUFFER_READ(pop_s),
      .HOLDING_WRITE(hold_s), .LINE_STATUS_READ(lsr_s), .MODEM_STATUS_READ(msr_s));

   // one-cycle strobes are tallied so a pulse between checks is not missed
   always @(posedge ref_clk)
   begin
      if (rst_b)
      begin
         n_pop   <= n_pop + {3'h0, pop_s};
         n_hold  <= n_hold + {3'h0, hold_s};
         n_lsr   <= n_lsr + {3'h0, lsr_s};
         n_msr   <= n_msr + {3'h0, msr_s};
         n_rxclr <= n_rxclr + {3'h0, rxclr_s};
         n_txclr <= n_txclr + {3'h0, txclr_s};
      end
   end

   // one-cycle event pulses, then time for flags and the pin to settle
   task ev(input logic [3:0] le, input logic [3:0] md, input logic th, input logic tk);
      @(posedge ref_clk);
      line_err <= le;
      modem_dl <= md;
      thr_ev <= th;
      tick <= tk;
      @(posedge ref_clk);
      {line_err, modem_dl, thr_ev, tick} <= 10'h000;
      repeat (3) @(posedge ref_clk);
   endtask : ev

   task iid(input logic [7:0] exp);
      host_model_inst.rd(3'h2, d);
      `CHK(d, exp)
   endtask : iid

   task t_format;
      for (int i = 0; i < 4; i++)
      begin
         host_model_inst.wr(3'h3, 8'(i));
         `CHK(data_bits, 4'h5 + 4'(i))
         host_model_inst.rd(3'h3, d);
         `CHK(d, 8'(i))
      end
      host_model_inst.wr(3'h3, 8'h80);
      iid(8'h01);
      host_model_inst.wr(3'h3, 8'h00);
      $display("test format done");
   endtask : t_format

   task t_priority;
      host_model_inst.wr(3'h1, 8'h0f);
      host_model_inst.wr(3'h4, 8'h08);
      iid(8'h01);
      ev(4'h0, 4'h2, 1'b0, 1'b0);
      `CHK(irq, 1'b1)
      iid(8'h00);
      fork
         iid(8'h00);
         begin
            repeat (4) @(posedge ref_clk);
            line_err <= 4'h8;
            @(posedge ref_clk);
            line_err <= 4'h0;
         end
      join
      ev(4'h0, 4'h0, 1'b1, 1'b0);
      rx_level <= 5'h01;
      iid(8'h06);
      host_model_inst.rd(3'h5, d);
      `CHK(n_lsr, 4'h1)
      iid(8'h04);
      rx_level <= 5'h00;
      iid(8'h02);
      iid(8'h00);
      host_model_inst.rd(3'h6, d);
      `CHK(n_msr, 4'h1)
      iid(8'h01);
      `CHK(irq, 1'b0)
      $display("test priority done");
   endtask : t_priority

   task t_gate;
      ev(4'h1, 4'h0, 1'b0, 1'b0);
      host_model_inst.wr(3'h4, 8'h00);
      `CHK({irq, irq_oe_b}, 2'h1)
      host_model_inst.wr(3'h1, 8'h00);
      iid(8'h01);
      host_model_inst.wr(3'h1, 8'h04);
      iid(8'h06);
      host_model_inst.rd(3'h5, d);
      `CHK(n_lsr, 4'h2)
      host_model_inst.wr(3'h1, 8'h0f);
      host_model_inst.wr(3'h4, 8'h08);
      // holding empty cleared by a holding write rather than an identification read
      ev(4'h0, 4'h0, 1'b1, 1'b0);
      `CHK(irq, 1'b1)
      host_model_inst.wr(3'h0, 8'h55);
      repeat (2) @(posedge ref_clk);
      `CHK(irq, 1'b0)
      `CHK(n_hold, 4'h1)
      $display("test gate done");
   endtask : t_gate

   task t_fifo;
      host_model_inst.wr(3'h2, 8'h01);
      iid(8'hc1);
      host_model_inst.wr(3'h2, 8'h47);
      `CHK({n_rxclr, n_txclr}, 8'h11)
      rx_level <= 5'h03;
      iid(8'hc1);
      rx_level <= 5'h04;
      iid(8'hc4);
      rx_level <= 5'h01;
      repeat (3) ev(4'h0, 4'h0, 1'b0, 1'b1);
      iid(8'hc1);
      // a new character restarts the four-character wait
      rx_push <= 1'b1;
      rx_level <= 5'h02;
      @(posedge ref_clk);
      rx_push <= 1'b0;
      ev(4'h0, 4'h0, 1'b0, 1'b1);
      `CHK(irq, 1'b0)
      repeat (3) ev(4'h0, 4'h0, 1'b0, 1'b1);
      `CHK(irq, 1'b1)
      iid(8'hcc);
      host_model_inst.rd(3'h0, d);
      `CHK(n_pop, 4'h1)
      iid(8'hc1);
      rx_level <= 5'h00;
      host_model_inst.wr(3'h2, 8'h00);
      `CHK({n_rxclr, n_txclr}, 8'h22)
      iid(8'h01);
      $display("test fifo done");
   endtask : t_fifo

   task results;
      $display("compared %0d, mismatched %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results

   // hang guard, far above the few hundred cycles the tests need
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         results();
      end
   end

   initial
   begin
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge ref_clk);
      iid(8'h01);
      t_format();
      t_priority();
      t_gate();
      t_fifo();
      results();
   end
endmodule : uart_interrupt_identification_tb_top

`default_nettype wire
